// ---- design/ascp_pkg.sv ----
// Constants for the converter serial control port.
package ascp_pkg;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int CS_FILT_NS    = 1425;
  localparam int CS_FILT_CYC   = (CS_FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CONV_NS       = 21000;
  localparam int CONV_CYC      = CONV_NS / CLK_PERIOD_NS;
  localparam int ABORT_NS      = 9000;
  localparam int ABORT_CYC     = ABORT_NS / CLK_PERIOD_NS;
  // ---------------------------------------------------------------
  // Framing and widths
  // ---------------------------------------------------------------
  localparam int RES_W      = 10;
  localparam int ADDR_W     = 4;
  localparam int SHORT_XFER = 10;
  localparam int LONG_XFER  = 16;
  localparam int ACQ_CLKS   = 6;
  localparam int ACQ_START  = SHORT_XFER - ACQ_CLKS;
  // ---------------------------------------------------------------
  // Self-test channels and reset values
  // ---------------------------------------------------------------
  localparam logic [3:0] ST_MID_ADDR  = 4'hB;
  localparam logic [3:0] ST_ZERO_ADDR = 4'hC;
  localparam logic [3:0] ST_FULL_ADDR = 4'hD;
  localparam logic [9:0] ST_MID_CODE  = 10'h200;
  localparam logic [9:0] ST_ZERO_CODE = 10'h000;
  localparam logic [9:0] ST_FULL_CODE = 10'h3FF;
  localparam logic [9:0] RESULT_RST   = 10'h000;
  typedef enum logic [0:0] {
    ASCP_IDLE = 1'b0,
    ASCP_CONV = 1'b1
  } ascp_conv_e;
endpackage

// ---- design/ascp_top.sv ----
// Serial control port, conversion sequencer and request FIFO of the converter.
// Contract
// - A select change counts only after it held for the filter interval.
// - After select falls, control inputs are ignored until the filter expires.
// - After select rises, address and serial clock are ignored within the filter; the code still counts serial clock edges until the filter expires.
// - Address bits in and result bits out are positive logic.
// - Ten-clock transfers work framed by select or with select held low.
// - Eleven to sixteen clock framed and sixteen clock unframed transfers work.
// - Self-test addresses 1011, 1100, 1101 give 512, 0 and 1023.
// - The channel is sampled over six serial clock periods per transfer.
// - Each conversion finishes at most 21 us after sampling ends; the code times 21 us from the FIFO pop, so a queued request finishes later.
// - Select falling within 9 us after the tenth falling clock aborts conversion.
`timescale 1ns/100ps

module ascp_fifo #(
  parameter int WIDTH = 14,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             rst,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  initial if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) $error("ascp_fifo: bad size");
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_q;
  logic [AW:0]      rd_q;
  wire              push = in_valid && in_ready;
  wire              pop  = out_valid && out_ready;
  assign in_ready  = (wr_q - rd_q) != (AW+1)'(DEPTH);
  assign out_valid = wr_q != rd_q;
  assign out_data  = mem[rd_q[AW-1:0]];
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wr_q[AW-1:0]] <= in_data;
    end
  end
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
    end
  end
endmodule // ascp_fifo

module ascp_top #(
  parameter int FIFO_DEPTH = 8
) (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst,
  // Serial pins
  input  wire logic       cs_n_pin,
  input  wire logic       io_clk_pin,
  input  wire logic       addr_pin,
  output logic            data_out,
  output logic            data_oe,
  output logic            eoc,
  // Analog front end sample, same clock
  input  wire logic [9:0] analog_code
);
  initial if (FIFO_DEPTH < 2) $error("ascp_top: FIFO_DEPTH too small");
  localparam int FILT_M1  = ascp_pkg::CS_FILT_CYC - 1;
  localparam int CONV_M1  = ascp_pkg::CONV_CYC - 1;
  localparam int FW       = ascp_pkg::ADDR_W + ascp_pkg::RES_W;

  function automatic logic [9:0] pick_code(input logic [3:0] ch, input logic [9:0] smp);
    case (ch)
      ascp_pkg::ST_MID_ADDR:  pick_code = ascp_pkg::ST_MID_CODE;
      ascp_pkg::ST_ZERO_ADDR: pick_code = ascp_pkg::ST_ZERO_CODE;
      ascp_pkg::ST_FULL_ADDR: pick_code = ascp_pkg::ST_FULL_CODE;
      default:                pick_code = smp;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [1:0] cs_s_q, clk_s_q, adr_s_q;
  logic       clk_d_q;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cs_s_q  <= 2'h3;
      clk_s_q <= 2'h0;
      adr_s_q <= 2'h0;
      clk_d_q <= 1'b0;
    end else begin
      cs_s_q  <= {cs_s_q[0], cs_n_pin};
      clk_s_q <= {clk_s_q[0], io_clk_pin};
      adr_s_q <= {adr_s_q[0], addr_pin};
      clk_d_q <= clk_s_q[1];
    end
  end
  wire sel_lvl = !cs_s_q[1];

  // ---------------------------------------------------------------
  // Select filter: noise pulses shorter than the interval are dropped
  // ---------------------------------------------------------------
  logic        sel_q;
  logic [11:0] filt_q;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sel_q  <= 1'b0;
      filt_q <= '0;
    end else if (sel_lvl == sel_q) begin
      filt_q <= '0;
    end else if (filt_q == 12'(FILT_M1)) begin
      sel_q  <= sel_lvl;
      filt_q <= '0;
    end else begin
      filt_q <= filt_q + 12'h001;
    end
  end
  logic sel_d1_q;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) sel_d1_q <= 1'b0;
    else     sel_d1_q <= sel_q;
  end
  wire sel_fall = sel_q && !sel_d1_q;
  // Serial clock only counts while the filtered select is active
  wire rise = sel_q && clk_s_q[1] && !clk_d_q;
  wire fall = sel_q && !clk_s_q[1] && clk_d_q;

  // ---------------------------------------------------------------
  // Transfer framing
  // ---------------------------------------------------------------
  logic [4:0] rcnt_q, fcnt_q;
  logic [3:0] addr_q;
  logic [9:0] smp_q;
  logic       acq_q, saw11_q, done_p;
  logic       push_ok;
  wire tenth = fall && fcnt_q == 5'(ascp_pkg::SHORT_XFER - 1);
  // A ten-clock transfer without the 11th rising edge ends at completion
  wire xfer_end = !sel_q || (fall && fcnt_q == 5'(ascp_pkg::LONG_XFER - 1))
                  || (done_p && !saw11_q && fcnt_q >= 5'(ascp_pkg::SHORT_XFER));
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rcnt_q  <= '0;
      fcnt_q  <= '0;
      saw11_q <= 1'b0;
      addr_q  <= '0;
    end else if (xfer_end) begin
      rcnt_q  <= '0;
      fcnt_q  <= '0;
      saw11_q <= 1'b0;
    end else begin
      if (rise) begin
        rcnt_q <= rcnt_q + 5'h01;
        if (rcnt_q < 5'(ascp_pkg::ADDR_W)) addr_q <= {addr_q[2:0], adr_s_q[1]};
        if (rcnt_q == 5'(ascp_pkg::SHORT_XFER)) saw11_q <= 1'b1;
      end
      if (fall) fcnt_q <= fcnt_q + 5'h01;
    end
  end
  // Acquisition: from the fourth to the tenth falling edge
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      acq_q <= 1'b0;
      smp_q <= '0;
    end else if (!sel_q || tenth) begin
      acq_q <= 1'b0;
      if (tenth) smp_q <= analog_code;
    end else if (fall && fcnt_q == 5'(ascp_pkg::ACQ_START - 1)) begin
      acq_q <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Request FIFO and conversion engine
  // ---------------------------------------------------------------
  logic          f_ready, f_valid;
  logic [FW-1:0] f_data;
  ascp_pkg::ascp_conv_e st_q;
  logic [11:0]   conv_q;
  logic [9:0]    abort_q;
  logic [9:0]    result_q;
  wire           abort = sel_fall && abort_q != '0;
  // A full FIFO refuses the request; that transfer yields no conversion
  assign push_ok = tenth && f_ready;
  ascp_fifo #(.WIDTH(FW), .DEPTH(FIFO_DEPTH)) u_fifo (
    .core_clk  (core_clk),
    .rst       (rst),
    .in_valid  (tenth),
    .in_ready  (f_ready),
    .in_data   ({addr_q, analog_code}),
    .out_valid (f_valid),
    .out_ready (st_q == ascp_pkg::ASCP_IDLE && !abort),
    .out_data  (f_data)
  );
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      abort_q <= '0;
    end else if (tenth) begin
      abort_q <= 10'(ascp_pkg::ABORT_CYC);
    end else if (abort_q != '0) begin
      abort_q <= abort_q - 10'h001;
    end
  end
  logic [FW-1:0] job_q;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_q     <= ascp_pkg::ASCP_IDLE;
      conv_q   <= '0;
      job_q    <= '0;
      result_q <= ascp_pkg::RESULT_RST;
      done_p   <= 1'b0;
    end else begin
      done_p <= 1'b0;
      case (st_q)
        ascp_pkg::ASCP_IDLE: begin
          if (f_valid && !abort) begin
            st_q   <= ascp_pkg::ASCP_CONV;
            job_q  <= f_data;
            conv_q <= '0;
          end
        end
        ascp_pkg::ASCP_CONV: begin
          if (abort) begin
            st_q <= ascp_pkg::ASCP_IDLE;
          end else if (conv_q == 12'(CONV_M1)) begin
            st_q     <= ascp_pkg::ASCP_IDLE;
            result_q <= pick_code(job_q[FW-1 -: 4], job_q[9:0]);
            done_p   <= 1'b1;
          end else begin
            conv_q <= conv_q + 12'h001;
          end
        end
        default: st_q <= ascp_pkg::ASCP_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Pin outputs
  // ---------------------------------------------------------------
  logic [9:0] out_sr_q;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      eoc <= 1'b1;
    end else if (push_ok) begin
      eoc <= 1'b0;
    end else if (done_p || (abort && !eoc)) begin
      eoc <= 1'b1;
    end
  end
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      out_sr_q <= ascp_pkg::RESULT_RST;
      data_oe  <= 1'b0;
    end else begin
      data_oe <= sel_q;
      if (done_p) out_sr_q <= pick_code(job_q[FW-1 -: 4], job_q[9:0]);
      else if (sel_fall || xfer_end) out_sr_q <= result_q;
      else if (fall) out_sr_q <= {out_sr_q[8:0], 1'b0};
    end
  end
  assign data_out = out_sr_q[9];

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  localparam int CHK_CONV = ascp_pkg::CONV_CYC + 2;
  // Conversion length is counted here, the bound is too long for a delay range
  logic [11:0] chk_cyc_q;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      chk_cyc_q <= '0;
    end else if (st_q == ascp_pkg::ASCP_CONV) begin
      chk_cyc_q <= chk_cyc_q + 12'h001;
    end else begin
      chk_cyc_q <= '0;
    end
  end
  sequence s_tenth_fall;
    tenth && f_ready;
  endsequence
  sequence s_eoc_low;
    !eoc;
  endsequence
  filter_hold_a: assert property (@(posedge core_clk) disable iff (rst)
    $changed(sel_q) |-> $past(filt_q) == 12'(FILT_M1)) else $error("select changed before filter expired");
  ignore_unsel_a: assert property (@(posedge core_clk) disable iff (rst)
    !sel_q && !$fell(sel_q) |=> $stable(fcnt_q) && $stable(addr_q))
    else $error("serial activity accepted while deselected");
  deselect_stop_a: assert property (@(posedge core_clk) disable iff (rst)
    $fell(sel_q) |=> rcnt_q == '0 && fcnt_q == '0) else $error("counters not cleared on deselect");
  selftest_mid_a: assert property (@(posedge core_clk) disable iff (rst)
    done_p && $past(job_q[FW-1 -: 4]) == ascp_pkg::ST_MID_ADDR |-> result_q == ascp_pkg::ST_MID_CODE)
    else $error("self-test code wrong");
  acq_window_a: assert property (@(posedge core_clk) disable iff (rst)
    tenth |-> acq_q) else $error("sampling window closed before tenth edge");
  conv_bound_a: assert property (@(posedge core_clk) disable iff (rst)
    s_eoc_low |-> chk_cyc_q < 12'(CHK_CONV))
    else $error("conversion overran");
  abort_conv_a: assert property (@(posedge core_clk) disable iff (rst)
    abort && st_q == ascp_pkg::ASCP_CONV |=> st_q == ascp_pkg::ASCP_IDLE ##1 eoc)
    else $error("abort ignored");
  eoc_fall_a: assert property (@(posedge core_clk) disable iff (rst)
    s_tenth_fall |=> s_eoc_low) else $error("done flag did not fall");
  eoc_msb_a: assert property (@(posedge core_clk) disable iff (rst)
    done_p |=> eoc && data_out == result_q[9]) else $error("MSB not presented at completion");
  drive_sel_a: assert property (@(posedge core_clk) disable iff (rst)
    data_oe |-> $past(sel_q)) else $error("output driven while deselected");
endmodule // ascp_top

// ---- dv/ascp_host.sv ----
// Host serial port model that frames transfers to the converter control port.
`timescale 1ns/100ps

module ascp_host (
  // Clock
  input  wire logic core_clk,
  // Serial pins
  output logic      cs_n_pin,
  output logic      io_clk_pin,
  output logic      addr_pin,
  input  wire logic data_out,
  input  wire logic eoc
);
  // ---------------------------------------------------------------
  // Idle pins
  // ---------------------------------------------------------------
  initial begin
    cs_n_pin   = 1'b1;
    io_clk_pin = 1'b0;
    addr_pin   = 1'b0;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic wait_eoc();
    int k;
    k = 0;
    while (eoc !== 1'b1 && k < 3000) begin
      cyc(1);
      k++;
    end
  endtask

  // ---------------------------------------------------------------
  // One transfer of n serial clocks, 16 core cycles a period, 5 more after the tenth
  // ---------------------------------------------------------------
  task automatic xfer(input logic framed, input logic wait_done, input int n, input logic [3:0] addr,
                      output logic [9:0] rd, output logic eoc_lo);
    rd     = 10'h000;
    eoc_lo = 1'b0;
    if (cs_n_pin) begin
      // Reselecting early aborts the running conversion, so only the abort case skips this
      if (wait_done) wait_eoc();
      cs_n_pin = 1'b0;
      cyc(150);
    end
    wait_eoc();
    for (int i = 0; i < n; i++) begin
      addr_pin = (i < 4) ? addr[3-i] : 1'b0;
      cyc(8);
      io_clk_pin = 1'b1;
      cyc(7);
      if (i < 10) rd[9-i] = data_out;
      cyc(1);
      io_clk_pin = 1'b0;
      if (i == 9) begin
        cyc(5);
        eoc_lo = (eoc === 1'b0);
      end
    end
    // Released address line shows the inverse rather than a stale bit
    addr_pin = ~addr_pin;
    if (framed) begin
      cyc(8);
      cs_n_pin = 1'b1;
      cyc(150);
    end
  endtask

  // Select pulse shorter than the filter, with serial clocks running under it
  task automatic glitch(input int n);
    cs_n_pin = 1'b0;
    repeat (n / 16) begin
      io_clk_pin = 1'b1;
      cyc(8);
      io_clk_pin = 1'b0;
      cyc(8);
    end
    cs_n_pin = 1'b1;
  endtask
endmodule // ascp_host

// ---- dv/ascp_top_test.sv ----
// Self-checking testbench for the converter serial control port.
`timescale 1ns/100ps

module ascp_top_test;
  logic       core_clk;
  logic       rst;
  logic       cs_n_pin;
  logic       io_clk_pin;
  logic       addr_pin;
  logic       data_out;
  logic       data_oe;
  logic       eoc;
  logic [9:0] analog_code;
  logic [9:0] rd;
  logic       lo;
  int         errors;
  int         tests_run;

  ascp_top i_ascp_top (.core_clk(core_clk), .rst(rst), .cs_n_pin(cs_n_pin), .io_clk_pin(io_clk_pin),
                       .addr_pin(addr_pin), .data_out(data_out), .data_oe(data_oe), .eoc(eoc),
                       .analog_code(analog_code));
  ascp_host i_ascp_host (.core_clk(core_clk), .cs_n_pin(cs_n_pin), .io_clk_pin(io_clk_pin),
                         .addr_pin(addr_pin), .data_out(data_out), .eoc(eoc));

  initial core_clk = 1'b0;
  always #5 core_clk = ~core_clk;

  // ---------------------------------------------------------------
  // Shared helpers
  // ---------------------------------------------------------------
  task automatic check(input logic [9:0] seen, input logic [9:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Each transfer returns the previous conversion result
  task automatic x(input logic fr, input logic wd, input int n, input logic [3:0] a, input logic [9:0] exp);
    i_ascp_host.xfer(fr, wd, n, a, rd, lo);
    check(rd, exp);
    check({9'h000, lo}, 10'h001);
    if (fr) check({9'h000, data_oe}, 10'h000);
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic s_selftest();
    int k;
    analog_code = 10'h15A;
    x(1'b1, 1'b1, 10, 4'hB, 10'h000);
    k = 0;
    while (eoc !== 1'b1 && k < 2200) begin
      @(posedge core_clk);
      k++;
    end
    check({9'h000, (k > 1800 && k <= 2100)}, 10'h001);
    x(1'b1, 1'b1, 16, 4'hC, 10'h200);
    x(1'b1, 1'b1, 12, 4'hD, 10'h000);
    x(1'b1, 1'b1, 10, 4'h3, 10'h3FF);
  endtask

  task automatic s_unframed();
    x(1'b0, 1'b1, 16, 4'hB, 10'h15A);
    x(1'b0, 1'b1, 16, 4'hC, 10'h200);
    x(1'b1, 1'b1, 10, 4'hC, 10'h000);
  endtask

  task automatic s_abort();
    x(1'b1, 1'b1, 10, 4'hB, 10'h000);
    // Reselect soon after the tenth clock kills the self-test conversion
    x(1'b1, 1'b0, 10, 4'hD, 10'h000);
    x(1'b1, 1'b1, 10, 4'hC, 10'h3FF);
  endtask

  task automatic s_glitch();
    logic bad;
    bad = 1'b0;
    // The last scenario leaves a conversion running; the done flag must be high first
    i_ascp_host.wait_eoc();
    fork
      i_ascp_host.glitch(112);
      repeat (300) begin
        @(posedge core_clk);
        #2;
        if (data_oe !== 1'b0 || eoc !== 1'b1) bad = 1'b1;
      end
    join
    check({9'h000, bad}, 10'h000);
    x(1'b1, 1'b1, 10, 4'hB, 10'h000);
  endtask

  // ---------------------------------------------------------------
  // Main sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    errors      = 0;
    tests_run   = 0;
    rst         = 1'b1;
    analog_code = 10'h000;
    repeat (4) @(posedge core_clk);
    #1;
    rst = 1'b0;
    s_selftest();
    s_unframed();
    s_abort();
    s_glitch();
    end_sim();
  end

  initial begin
    #600000;
    errors++;
    end_sim();
  end
endmodule // ascp_top_test
